// ---- rtl/chip_select_pkg.sv ----
// Package for the four-channel chip-select decoder: register map, field layout,
// reset values and the bus-mode carrier type.
// Assumes a 32-bit APB register port and a 24-bit processor address.
package chip_select_pkg;

    // ==========================================================================
    // Register map, as indices; byte address is four times the index.
    // ==========================================================================
    localparam logic [7:0] select0_lower_bound_idx = 8'ha8;
    localparam logic [7:0] select0_upper_bound_idx = 8'ha9;
    localparam logic [7:0] select0_control_idx = 8'haa;
    localparam logic [7:0] select1_lower_bound_idx = 8'hab;
    localparam logic [7:0] select1_upper_bound_idx = 8'hac;
    localparam logic [7:0] select1_control_idx = 8'had;
    localparam logic [7:0] select2_lower_bound_idx = 8'hae;
    localparam logic [7:0] select2_upper_bound_idx = 8'haf;
    localparam logic [7:0] select2_control_idx = 8'hb0;
    localparam logic [7:0] select3_lower_bound_idx = 8'hb1;
    localparam logic [7:0] select3_upper_bound_idx = 8'hb2;
    localparam logic [7:0] select3_control_idx = 8'hb3;
    localparam int regs_per_channel = 3;
    localparam int num_channels = 4;

    // ==========================================================================
    // Control register fields.
    // ==========================================================================
    localparam int wait_lsb = 5;
    localparam int wait_msb = 7;
    localparam int io_bit = 4;
    localparam int enable_bit = 3;
    localparam logic [7:0] control_writable_mask = 8'hf8;

    // ==========================================================================
    // Reset values.
    // ==========================================================================
    localparam logic [7:0] lower_bound_reset = 8'h00;
    localparam logic [7:0] upper_bound0_reset = 8'hff;
    localparam logic [7:0] upper_bound_reset = 8'h00;
    localparam logic [7:0] control0_reset = 8'he8;
    localparam logic [7:0] control_reset = 8'h00;

    // ==========================================================================
    // Bus modes; the native mode is the default one.
    // ==========================================================================
    localparam logic [1:0] mode_native = 2'h0;

    // One access request from the core.
    typedef struct packed {
        logic valid;
        logic [23:0] addr;
        logic [1:0] bus_mode;
    } access_req_t;

endpackage

// ---- rtl/chip_select_decoder.sv ----
// Four-channel chip-select decoder with APB configuration registers.
// Assumes the core presents one access request at a time, held until req_ready.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module chip_select_decoder
    import chip_select_pkg::*;
#(
    parameter int addr_width = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [addr_width-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire chip_select_pkg::access_req_t req,
    output logic req_ready,
    output logic [3:0] select_mem,
    output logic [3:0] select_io,
    output logic wait_active
);
    import chip_select_pkg::*;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_turn = 4'b0010,
        st_wait = 4'b0100,
        st_done = 4'b1000
    } state_t;

    // ==========================================================================
    // Register file.
    // ==========================================================================
    logic [7:0] lower_r [num_channels];
    logic [7:0] upper_r [num_channels];
    logic [7:0] control_r [num_channels];
    logic [7:0] word_idx;
    logic addr_hit;
    logic [1:0] hit_ch;
    logic [1:0] hit_kind;
    logic wr_en;

    // Index decode: only aligned word addresses inside the map hit.
    always_comb begin
        word_idx = paddr[9:2];
        addr_hit = 1'b0;
        hit_ch = 2'h0;
        hit_kind = 2'h0;
        for (int c = 0; c < num_channels; c++) begin
            for (int k = 0; k < regs_per_channel; k++) begin
                if (paddr[1:0] == 2'h0 && paddr[addr_width-1:10] == '0 &&
                    word_idx == select0_lower_bound_idx + 8'(c * regs_per_channel + k)) begin
                    addr_hit = 1'b1;
                    hit_ch = 2'(c);
                    hit_kind = 2'(k);
                end
            end
        end
    end

    // Zero-wait slave; unmapped addresses answer with pslverr.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign wr_en = psel && penable && pwrite && addr_hit;

    generate
        for (genvar g = 0; g < num_channels; g++) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lower_r[g] <= lower_bound_reset;
                    upper_r[g] <= (g == 0) ? upper_bound0_reset : upper_bound_reset;
                    control_r[g] <= (g == 0) ? control0_reset : control_reset;
                end else if (wr_en && hit_ch == 2'(g)) begin
                    case (hit_kind)
                        2'h0: lower_r[g] <= pwdata[7:0];
                        2'h1: upper_r[g] <= pwdata[7:0];
                        // Reserved bits are masked so they can never hold a one.
                        2'h2: control_r[g] <= pwdata[7:0] & control_writable_mask;
                        default: ;
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite && addr_hit) begin
            case (hit_kind)
                2'h0: prdata <= {24'h00_0000, lower_r[hit_ch]};
                2'h1: prdata <= {24'h00_0000, upper_r[hit_ch]};
                default: prdata <= {24'h00_0000, control_r[hit_ch]};
            endcase
        end else if (psel && !penable) begin
            prdata <= 32'h0000_0000;
        end
    end

    // ==========================================================================
    // Address decode.
    // ==========================================================================
    logic [3:0] mem_hit;
    logic [3:0] io_hit;
    generate
        for (genvar g = 0; g < num_channels; g++) begin : g_dec
            logic en;
            logic is_io;
            assign en = control_r[g][enable_bit];
            assign is_io = control_r[g][io_bit];
            // Inclusive window on the top address byte for memory; I/O matches the middle byte to the lower bound, upper bound ignored.
            assign mem_hit[g] = en && !is_io && req.addr[23:16] >= lower_r[g] &&
                req.addr[23:16] <= upper_r[g];
            assign io_hit[g] = en && is_io && req.addr[15:8] == lower_r[g];
        end
    endgenerate

    // Lowest channel wins when windows overlap, so at most one select is live.
    logic [3:0] pick;
    logic [2:0] pick_wait;
    always_comb begin
        pick = 4'h0;
        pick_wait = 3'h0;
        for (int c = num_channels - 1; c >= 0; c--) begin
            if (mem_hit[c] || io_hit[c]) begin
                pick = 4'(1 << c);
                pick_wait = control_r[c][wait_msb:wait_lsb];
            end
        end
    end

    // ==========================================================================
    // Access sequencer.
    // ==========================================================================
    state_t state_r;
    logic [1:0] last_mode_r;
    logic [2:0] wait_cnt_r;
    logic [3:0] sel_r;
    logic [3:0] sel_io_r;
    logic need_turn;
    logic [2:0] eff_wait;

    assign need_turn = req.bus_mode != last_mode_r && req.bus_mode != mode_native;
    assign eff_wait = (req.bus_mode == mode_native) ? pick_wait : 3'h0;
    assign req_ready = state_r == st_done;
    assign wait_active = state_r == st_wait || state_r == st_turn;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= st_idle;
            wait_cnt_r <= 3'h0;
        end else begin
            case (state_r)
                st_idle: begin
                    if (req.valid) begin
                        if (need_turn) begin
                            state_r <= st_turn;
                        end else if (eff_wait != 3'h0) begin
                            state_r <= st_wait;
                        end else begin
                            state_r <= st_done;
                        end
                        wait_cnt_r <= eff_wait;
                    end
                end
                st_turn: begin
                    state_r <= (wait_cnt_r != 3'h0) ? st_wait : st_done;
                end
                st_wait: begin
                    // One cycle per programmed wait state.
                    if (wait_cnt_r == 3'h1) begin
                        state_r <= st_done;
                    end
                    wait_cnt_r <= wait_cnt_r - 3'h1;
                end
                st_done: state_r <= st_idle;
                default: state_r <= st_idle;
            endcase
        end
    end

    // The mode is remembered at completion so the next access sees the change.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_mode_r <= mode_native;
        end else if (state_r == st_done) begin
            last_mode_r <= req.bus_mode;
        end
    end

    // Selects are registered and held for the whole access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= 4'h0;
            sel_io_r <= 4'h0;
        end else if (state_r == st_idle && req.valid) begin
            sel_r <= pick & mem_hit;
            sel_io_r <= pick & io_hit;
        end else if (state_r == st_done) begin
            sel_r <= 4'h0;
            sel_io_r <= 4'h0;
        end
    end

    assign select_mem = sel_r;
    assign select_io = sel_io_r;

endmodule

`default_nettype wire

// ---- testbench/chip_select_sva.sv ----
// Port checker for the chip-select decoder.
// Assumes it is bound onto chip_select_decoder.
`timescale 1ns/1ps
`default_nettype none
module chip_select_sva
    import chip_select_pkg::*;
#(
    parameter int addr_width = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [addr_width-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire chip_select_pkg::access_req_t req,
    input wire logic req_ready,
    input wire logic [3:0] select_mem,
    input wire logic [3:0] select_io,
    input wire logic wait_active
);
    // ====================
    // Helpers
    logic any_sel, mapped, is_ctl;
    logic [7:0] idx;
    logic [3:0] wcnt_r;
    assign any_sel = |{select_mem, select_io};
    assign idx = paddr[9:2];
    assign mapped = paddr[1:0] == 2'h0 && paddr[addr_width-1:10] == '0
        && idx >= select0_lower_bound_idx && idx <= select3_control_idx;
    assign is_ctl = mapped && (idx inside {select0_control_idx, select1_control_idx,
        select2_control_idx, select3_control_idx});
    // The turnaround and the wait states never share one access, so seven is the ceiling.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wcnt_r <= 4'h0;
        else if (wait_active) wcnt_r <= wcnt_r + 4'h1;
        else wcnt_r <= 4'h0;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_held;
        any_sel throughout (##[0:8] req_ready);
    endsequence
    sequence s_freed;
        ##1 !any_sel;
    endsequence
    // ====================
    // Properties
    a_select_lifetime:
        assert property ($rose(any_sel) |-> s_held ##0 s_freed) else $error("select span");
    a_ready_pulse:
        assert property (req_ready |=> !req_ready) else $error("ready not a pulse");
    a_single_select:
        assert property ($onehot0({select_mem, select_io})) else $error("several selects");
    a_wait_bound:
        assert property (wcnt_r <= 4'h7) else $error("too many wait cycles");
    // Outside native mode the wait count is ignored, so only the single turn cycle is left.
    a_turn_single:
        assert property (wait_active && req.bus_mode != mode_native |=> !wait_active)
        else $error("long turn");
    // In native mode a stall can only come from the wait states of a live select.
    a_turn_mode:
        assert property ($rose(wait_active) && req.bus_mode == mode_native |-> any_sel)
        else $error("turn in native mode");
    a_ctl_reserved:
        assert property (psel && penable && !pwrite && is_ctl |-> prdata[2:0] == 3'h0)
        else $error("reserved bits set");
    a_unmapped_err:
        assert property (psel && penable && !mapped |-> pslverr && (pwrite || prdata == 0))
        else $error("unmapped access");
    a_select_cause:
        assert property ($rose(any_sel) |-> $past(req.valid)) else $error("select w/o req");
endmodule
bind chip_select_decoder chip_select_sva #(.addr_width(addr_width)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req(req), .req_ready(req_ready), .select_mem(select_mem), .select_io(select_io),
    .wait_active(wait_active));
`default_nettype wire

// ---- testbench/select_target.sv ----
// Model of the memories and peripherals behind the select lines.
// Assumes selects stay up until the edge that ends the ready cycle.
`timescale 1ns/1ps
`default_nettype none
module select_target (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] select_mem,
    input wire logic [3:0] select_io,
    input wire logic req_ready,
    output logic [3:0] hit_mem_r,
    output logic [3:0] hit_io_r
);
    // ====================
    // Capture of the device that answered the last access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_mem_r <= 4'h0;
            hit_io_r <= 4'h0;
        end else if (req_ready) begin
            hit_mem_r <= select_mem;
            hit_io_r <= select_io;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the chip-select decoder.
// Assumes the checker is bound and the target model is compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import chip_select_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_ready, wait_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] select_mem, select_io, hit_mem, hit_io;
    access_req_t req;
    int failures = 0;
    int compares = 0;
    chip_select_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req(req), .req_ready(req_ready), .select_mem(select_mem),
        .select_io(select_io), .wait_active(wait_active));
    select_target target (.pclk(pclk), .presetn(presetn), .select_mem(select_mem),
        .select_io(select_io), .req_ready(req_ready), .hit_mem_r(hit_mem), .hit_io_r(hit_io));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ====================
    // Tasks
    task automatic stop_test;
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, wd, d, e);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic eerr = 1'b0);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 8'h00, d, e);
        check(d, {24'h0, exp}, "read data");
        check({31'h0, e}, {31'h0, eerr}, "error flag");
    endtask
    task automatic access(input logic [23:0] a, input logic [1:0] m, input logic [3:0] em,
        input logic [3:0] ei, input int lat);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{valid: 1'b1, addr: a, bus_mode: m};
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (req_ready !== 1'b1 && n < 20);
        @(posedge pclk);
        req.valid <= 1'b0;
        #1;
        check(n, lat, "latency");
        check({24'h0, hit_mem, hit_io}, {24'h0, em, ei}, "selects");
    endtask
    // ====================
    // Tests
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        req = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++) rd(select0_lower_bound_idx + 8'(i),
            i == 1 ? 8'hff : i == 2 ? 8'he8 : 8'h00);
        rd(8'h00, 8'h00, 1'b1);
        rd(8'hb4, 8'h00, 1'b1);
        access(24'h123456, 2'h0, 4'h1, 4'h0, 8);
        wr(select3_control_idx, 8'hff);
        rd(select3_control_idx, 8'hf8);
        wr(select3_control_idx, 8'h00);
        wr(select1_lower_bound_idx, 8'h40);
        wr(select1_upper_bound_idx, 8'h4f);
        wr(select1_control_idx, 8'h48);
        wr(select2_lower_bound_idx, 8'h12);
        wr(select2_control_idx, 8'h18);
        rd(select1_upper_bound_idx, 8'h4f);
        access(24'h400000, 2'h0, 4'h1, 4'h0, 8);
        wr(select0_control_idx, 8'h00);
        access(24'h400000, 2'h0, 4'h2, 4'h0, 3);
        access(24'h4fffff, 2'h0, 4'h2, 4'h0, 3);
        access(24'h3fffff, 2'h0, 4'h0, 4'h0, 1);
        access(24'h500000, 2'h0, 4'h0, 4'h0, 1);
        access(24'h001234, 2'h0, 4'h0, 4'h4, 1);
        access(24'h001334, 2'h0, 4'h0, 4'h0, 1);
        access(24'h4a0000, 2'h2, 4'h2, 4'h0, 2);
        access(24'h4a0000, 2'h2, 4'h2, 4'h0, 1);
        access(24'h4a0000, 2'h3, 4'h2, 4'h0, 2);
        access(24'h4a0000, 2'h0, 4'h2, 4'h0, 3);
        wr(select1_control_idx, 8'h40);
        access(24'h4a0000, 2'h0, 4'h0, 4'h0, 1);
        stop_test();
    end
    initial begin
        #200000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
